// ---- hdl/fps_consts.svh ----
`ifndef FPS_CONSTS_SVH
`define FPS_CONSTS_SVH

// register byte offsets
`define FPS_OFF_CTRL    8'h00
`define FPS_OFF_STATUS  8'h04
`define FPS_OFF_PRESENT 8'h08
`define FPS_OFF_INTSEG  8'h0C
`define FPS_OFF_COMMIT  8'h10
`define FPS_OFF_DESC    8'h14

// control register fields
`define FPS_CTRL_SEG    0
`define FPS_CTRL_CDESC  1
`define FPS_CTRL_PDESC  2
`define FPS_CTRL_IQ     3
`define FPS_CTRL_SRC_LO 4
`define FPS_CTRL_SRC_HI 5
`define FPS_CTRL_PLAY   6
`define FPS_CTRL_CSUB   7
`define FPS_CTRL_PSUB   8

// status register fields
`define FPS_ST_SEG_HI   15
`define FPS_ST_PRESENT  16
`define FPS_ST_REFUSED  17
`define FPS_ST_VALID    18

// reset values
`define FPS_CTRL_RST    9'h000
`define FPS_COMMIT_RST  8'hFF
`define FPS_PRESENT_RST 32'h0000_0000

// input sampling rate
`define FPS_SAMPLE_MBPS 250
`define FPS_CLK_MHZ     250

`endif

// ---- hdl/fps_pkg.sv ----
package fps_pkg;

  typedef enum logic [1:0] {
    FPS_SRC_INTERNAL = 2'b00,
    FPS_SRC_FAST     = 2'b01,
    FPS_SRC_SEQ      = 2'b10,
    FPS_SRC_MULTI    = 2'b11
  } fps_src_t;

  typedef logic [15:0] fps_word_t;

endpackage : fps_pkg

// ---- hdl/fps_rx.sv ----
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "fps_consts.svh"
// Behaviour
// - segment stream mode turns on only while all other port modes are off.
// - control descriptor mode excludes every other port mode.
// - pulse descriptor mode excludes every other port mode.
// - control mode: bits 15:8 are address, bits 7:0 are parameter.
// - pulse mode splits each word the same way.
// - inputs sampled every 4 ns; valid toggles no faster.
// - a new edge with a different identifier switches playback segment.
// - an identifier with no stored waveform replays no modulation.
// - commit code ends a control descriptor and applies it.
// - commit code closes a pulse descriptor; next pairs go onward.
// - source selector internal, port, sequencer or multi; only port uses ids.
// - playback data streams only while waveform playback is enabled.
// - identifiers accepted only while segment stream mode is enabled.
// - control pairs used only with control subsystem and mode enabled.
// - pulse pairs used only with pulse subsystem and mode enabled.
// - segment mode takes a 16-bit identifier marked by valid.
module fps_rx
  import fps_pkg::*;
#(
  parameter int SEG_SLOTS = 32,
  parameter int DATA_W    = 16
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // fast control port pins
  input  wire logic [15:0] fp_data,
  input  wire logic        fp_valid,
  // other segment sources, same clock
  input  wire logic [15:0] seq_segment_id,
  input  wire logic [15:0] mf_segment_id,
  // playback side
  output logic [15:0]      play_segment,
  output logic             play_stream_en,
  output logic             play_switch,
  // descriptor subsystem side
  output logic [7:0]       desc_addr,
  output logic [7:0]       desc_param,
  output logic             ctrl_desc_strobe,
  output logic             ctrl_desc_apply,
  output logic             pulse_desc_strobe,
  output logic             pulse_desc_close,
  output logic [7:0]       pulse_desc_index
);

  localparam int SAMPLE_NS = 1000 / `FPS_SAMPLE_MBPS;
  localparam int CLK_NS    = 1000 / `FPS_CLK_MHZ;

  // one sample per clock; a slower clock would miss 4 ns pulses
  if (CLK_NS > SAMPLE_NS) begin : g_chk_clk
    $error("clock slower than sample rate");
  end
  if (SEG_SLOTS < 1 || SEG_SLOTS > 32) begin : g_chk_slots
    $error("SEG_SLOTS 1..32");
  end
  if (DATA_W != 16) begin : g_chk_width
    $error("DATA_W must be 16");
  end

  // register state
  logic [8:0]           ctrl_ff;
  logic [SEG_SLOTS-1:0] present_ff;
  logic [15:0]          int_seg_ff;
  logic [7:0]           commit_ff;
  logic                 refused_ff;
  logic [31:0]          prdata_ff;
  logic                 pready_ff;
  logic                 pslverr_ff;

  // input sampling
  logic [15:0] d_s1_ff;
  logic [15:0] d_s2_ff;
  logic [15:0] d_s3_ff;
  logic [15:0] d_lvl_ff;
  logic        v_s1_ff;
  logic        v_s2_ff;
  logic        v_s3_ff;
  logic        v_lvl_ff;
  logic [15:0] nxt_d_lvl;
  logic        nxt_v_lvl;
  logic        v_rise;

  // datapath state
  logic [15:0] fp_seg_ff;
  logic [15:0] play_seg_ff;
  logic        play_en_ff;
  logic        switch_ff;
  logic [7:0]  addr_ff;
  logic [7:0]  param_ff;
  logic        cstb_ff;
  logic        capply_ff;
  logic        pstb_ff;
  logic        pclose_ff;
  logic [7:0]  pidx_ff;

  // decoded controls
  logic     seg_mode;
  logic     cdesc_mode;
  logic     pdesc_mode;
  fps_src_t src;
  logic     play_en_cfg;
  logic     csub_en;
  logic     psub_en;
  logic     wr_acc;
  logic     setup;
  logic     mapped;
  logic     ctrl_wr_ok;
  logic [3:0] mode_old, mode_new;
  logic [15:0] sel_seg;
  logic       sel_present;
  logic [31:0] present_all;

  assign seg_mode    = ctrl_ff[`FPS_CTRL_SEG];
  assign cdesc_mode  = ctrl_ff[`FPS_CTRL_CDESC];
  assign pdesc_mode  = ctrl_ff[`FPS_CTRL_PDESC];
  assign src         = fps_src_t'(ctrl_ff[`FPS_CTRL_SRC_HI:`FPS_CTRL_SRC_LO]);
  assign play_en_cfg = ctrl_ff[`FPS_CTRL_PLAY];
  assign csub_en     = ctrl_ff[`FPS_CTRL_CSUB];
  assign psub_en     = ctrl_ff[`FPS_CTRL_PSUB];

  assign setup  = psel & ~penable & ~pready_ff;
  assign wr_acc = psel & penable & pready_ff & pwrite;

  always_comb begin
    unique case (paddr)
      `FPS_OFF_CTRL, `FPS_OFF_STATUS, `FPS_OFF_PRESENT,
      `FPS_OFF_INTSEG, `FPS_OFF_COMMIT, `FPS_OFF_DESC: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // mode field accepted only if at most one mode ends up on and no
  // mode is swapped for another without first going through all-off
  assign mode_old = ctrl_ff[`FPS_CTRL_IQ:`FPS_CTRL_SEG];
  assign mode_new = pwdata[`FPS_CTRL_IQ:`FPS_CTRL_SEG];
  always_comb begin
    ctrl_wr_ok = 1'b1;
    if ($countones(mode_new) > 1) begin
      ctrl_wr_ok = 1'b0;
    end else if (mode_old != 4'h0 && mode_new != 4'h0 &&
                 mode_new != mode_old) begin
      ctrl_wr_ok = 1'b0;
    end
  end

  // apb: setup latches the answer, access cycle shows pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup) begin
        prdata_ff <= 32'h0000_0000;
        if (!pwrite) begin
          unique case (paddr)
            `FPS_OFF_CTRL:    prdata_ff <= {23'h0, ctrl_ff};
            `FPS_OFF_STATUS:  prdata_ff <= {13'h0, v_lvl_ff, refused_ff,
                                            sel_present, play_seg_ff};
            `FPS_OFF_PRESENT: prdata_ff <= 32'(present_ff);
            `FPS_OFF_INTSEG:  prdata_ff <= {16'h0, int_seg_ff};
            `FPS_OFF_COMMIT:  prdata_ff <= {24'h0, commit_ff};
            `FPS_OFF_DESC:    prdata_ff <= {8'h0, pidx_ff, addr_ff,
                                            param_ff};
            default:          prdata_ff <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff    <= `FPS_CTRL_RST;
      present_ff <= SEG_SLOTS'(`FPS_PRESENT_RST);
      int_seg_ff <= 16'h0000;
      commit_ff  <= `FPS_COMMIT_RST;
    end else if (wr_acc) begin
      unique case (paddr)
        `FPS_OFF_CTRL: begin
          if (ctrl_wr_ok) begin
            ctrl_ff <= pwdata[8:0];
          end else begin
            // mode bits kept, rest of the word still lands
            ctrl_ff <= {pwdata[8:4], mode_old};
          end
        end
        `FPS_OFF_PRESENT: present_ff <= pwdata[SEG_SLOTS-1:0];
        `FPS_OFF_INTSEG:  int_seg_ff <= pwdata[15:0];
        `FPS_OFF_COMMIT:  commit_ff  <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // sticky refused flag, write one to status bit to clear; a new
  // refusal in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_ff <= 1'b0;
    end else if (wr_acc && paddr == `FPS_OFF_CTRL && !ctrl_wr_ok) begin
      refused_ff <= 1'b1;
    end else if (wr_acc && paddr == `FPS_OFF_STATUS &&
                 pwdata[`FPS_ST_REFUSED]) begin
      refused_ff <= 1'b0;
    end
  end

  // three-stage sampler, every pclk is one 4 ns sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_s1_ff <= 16'h0000;
      d_s2_ff <= 16'h0000;
      d_s3_ff <= 16'h0000;
      v_s1_ff <= 1'b0;
      v_s2_ff <= 1'b0;
      v_s3_ff <= 1'b0;
    end else begin
      d_s1_ff <= fp_data;
      d_s2_ff <= d_s1_ff;
      d_s3_ff <= d_s2_ff;
      v_s1_ff <= fp_valid;
      v_s2_ff <= v_s1_ff;
      v_s3_ff <= v_s2_ff;
    end
  end

  // a level change counts once stages two and three agree
  for (genvar i = 0; i < 16; i++) begin : g_bit
    assign nxt_d_lvl[i] = (d_s2_ff[i] == d_s3_ff[i]) ? d_s3_ff[i]
                                                     : d_lvl_ff[i];
  end
  assign nxt_v_lvl = (v_s2_ff == v_s3_ff) ? v_s3_ff : v_lvl_ff;
  // valid held high never rises again until it has been seen low
  assign v_rise = nxt_v_lvl & ~v_lvl_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_lvl_ff <= 16'h0000;
      v_lvl_ff <= 1'b0;
    end else begin
      d_lvl_ff <= nxt_d_lvl;
      v_lvl_ff <= nxt_v_lvl;
    end
  end

  // segment identifier capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fp_seg_ff <= 16'h0000;
    end else if (v_rise && seg_mode) begin
      fp_seg_ff <= nxt_d_lvl;
    end
  end

  // segment source selection
  always_comb begin
    unique case (src)
      FPS_SRC_FAST: sel_seg = fp_seg_ff;
      FPS_SRC_SEQ:  sel_seg = seq_segment_id;
      FPS_SRC_MULTI: sel_seg = mf_segment_id;
      FPS_SRC_INTERNAL: sel_seg = int_seg_ff;
    endcase
  end
  // ids beyond the table have no stored waveform
  // table padded to 32 so any five-bit index stays legal
  assign present_all = 32'(present_ff);
  assign sel_present = (sel_seg < 16'(SEG_SLOTS)) &&
                       present_all[sel_seg[4:0]];

  // playback control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      play_seg_ff <= 16'h0000;
      play_en_ff  <= 1'b0;
      switch_ff   <= 1'b0;
    end else begin
      play_seg_ff <= sel_seg;
      play_en_ff  <= play_en_cfg & sel_present;
      // pulse only when the identifier really changes
      switch_ff   <= play_en_cfg & (sel_seg != play_seg_ff);
    end
  end

  // descriptor pairs, split into address and parameter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_ff   <= 8'h00;
      param_ff  <= 8'h00;
      cstb_ff   <= 1'b0;
      pstb_ff   <= 1'b0;
      capply_ff <= 1'b0;
      pclose_ff <= 1'b0;
    end else begin
      cstb_ff   <= v_rise & cdesc_mode & csub_en;
      pstb_ff   <= v_rise & pdesc_mode & psub_en;
      capply_ff <= v_rise & cdesc_mode & csub_en &
                   (nxt_d_lvl[7:0] == commit_ff);
      pclose_ff <= v_rise & pdesc_mode & psub_en &
                   (nxt_d_lvl[7:0] == commit_ff);
      if (v_rise && ((cdesc_mode && csub_en) || (pdesc_mode && psub_en)))
      begin
        addr_ff  <= nxt_d_lvl[15:8];
        param_ff <= nxt_d_lvl[7:0];
      end
    end
  end

  // pulse descriptor index advances on each close
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pidx_ff <= 8'h00;
    end else if (!pdesc_mode) begin
      pidx_ff <= 8'h00;
    end else if (v_rise && psub_en && nxt_d_lvl[7:0] == commit_ff) begin
      pidx_ff <= pidx_ff + 8'h01;
    end
  end

  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pslverr           = pslverr_ff;
  assign play_segment      = play_seg_ff;
  assign play_stream_en    = play_en_ff;
  assign play_switch       = switch_ff;
  assign desc_addr         = addr_ff;
  assign desc_param        = param_ff;
  assign ctrl_desc_strobe  = cstb_ff;
  assign ctrl_desc_apply   = capply_ff;
  assign pulse_desc_strobe = pstb_ff;
  assign pulse_desc_close  = pclose_ff;
  assign pulse_desc_index  = pidx_ff;

endmodule : fps_rx

// ---- testbench/fps_rx_properties.sv ----
`timescale 1ns/1ps
module fps_rx_properties (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // port and results
  input wire logic [15:0] fp_data,
  input wire logic        fp_valid,
  input wire logic [15:0] play_segment,
  input wire logic        play_switch,
  input wire logic [7:0]  desc_addr,
  input wire logic [7:0]  desc_param,
  input wire logic        ctrl_desc_strobe,
  input wire logic        ctrl_desc_apply,
  input wire logic        pulse_desc_strobe,
  input wire logic        pulse_desc_close
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pair;
    ctrl_desc_strobe || pulse_desc_strobe;
  endsequence
  sequence s_held;
    fp_valid [*8];
  endsequence
  a_setup_ready: assert property (psel && !penable && !pready |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_desc_split: assert property (
    s_pair |-> {desc_addr, desc_param} == $past(fp_data, 4))
    else $error("pair not taken from word");
  a_strobe_cause: assert property (
    s_pair |-> $past(fp_valid, 4) && !$past(fp_valid, 5))
    else $error("strobe without valid rise");
  a_held_once: assert property (
    s_held |-> !ctrl_desc_strobe && !pulse_desc_strobe)
    else $error("held valid captured again");
  a_modes_apart: assert property (
    !(ctrl_desc_strobe && pulse_desc_strobe))
    else $error("two modes at once");
  a_apply_pair: assert property (
    ctrl_desc_apply |-> ctrl_desc_strobe)
    else $error("apply without pair");
  a_close_pair: assert property (
    pulse_desc_close |-> pulse_desc_strobe)
    else $error("close without pair");
  a_switch_new: assert property (
    play_switch |-> play_segment != $past(play_segment))
    else $error("switch without new id");
endmodule : fps_rx_properties

bind fps_rx fps_rx_properties u_props (.*);

// ---- testbench/fps_sender.sv ----
`timescale 1ns/1ps
module fps_sender
  import fps_pkg::*;
(
  // port pins toward the device
  input  wire logic pclk,
  output fps_word_t fp_data,
  output logic      fp_valid
);
  initial begin
    fp_valid = 1'h0;
    fp_data  = 16'h0000;
  end
  // data settles 3 samples before the rise and stays well after it
  task automatic send(input fps_word_t w, input int hold);
    @(posedge pclk) fp_data <= w;
    repeat (3) @(posedge pclk);
    fp_valid <= 1'h1;
    repeat (hold) @(posedge pclk);
    fp_valid <= 1'h0;
    repeat (2) @(posedge pclk);
    // released data means nothing: show its inverse
    fp_data  <= ~w;
    repeat (4) @(posedge pclk);
  endtask : send
endmodule : fps_sender

// ---- testbench/fps_rx_tb.sv ----
`timescale 1ns/1ps
`include "fps_consts.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
$display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module fps_rx_tb
  import fps_pkg::*;
;
  localparam int SLOTS = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        fp_valid, play_stream_en, play_switch, ctrl_desc_strobe;
  logic        ctrl_desc_apply, pulse_desc_strobe, pulse_desc_close;
  logic [7:0]  paddr, desc_addr, desc_param, pulse_desc_index;
  logic [15:0] fp_data, seq_segment_id, mf_segment_id, play_segment, id;
  logic [31:0] pwdata, prdata, rd, pres;
  fps_word_t   w;
  int          n_errors, n_compared, cyc, n_sw, e_sw, c0, p0;
  int          n_s[2], n_c[2];

  fps_rx #(.SEG_SLOTS(SLOTS)) u_dut (.*);
  fps_sender u_snd (.*);

  initial pclk = 1'h0;
  always #2 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    n_sw   += (play_switch === 1'h1);
    n_s[0] += (ctrl_desc_strobe === 1'h1);
    n_s[1] += (pulse_desc_strobe === 1'h1);
    n_c[0] += (ctrl_desc_apply === 1'h1);
    n_c[1] += (pulse_desc_close === 1'h1);
    // the run needs about 600 cycles
    if (cyc == 8000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK(rd, e)
  endtask : rd_chk

  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seq_segment_id = 16'h0000;
    mf_segment_id = 16'h0000;
    void'($urandom(32'hCBEDFDAE));
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    rd_chk(`FPS_OFF_CTRL, 32'h0);
    rd_chk(`FPS_OFF_PRESENT, 32'h0);
    rd_chk(`FPS_OFF_COMMIT, 32'h0000_00FF);
    apb(1'h0, 8'h3C, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
    // every switch among segment, control and pulse descriptor modes is refused
    for (int i = 0; i < 3; i++)
      for (int j = 0; j < 3; j++) if (i != j) begin
        apb(1'h1, `FPS_OFF_STATUS, 32'h0002_0000);
        apb(1'h1, `FPS_OFF_CTRL, 32'h0);
        apb(1'h1, `FPS_OFF_CTRL, 32'h1 << i);
        apb(1'h1, `FPS_OFF_CTRL, 32'h1 << j);
        rd_chk(`FPS_OFF_CTRL, 32'h1 << i);
        apb(1'h0, `FPS_OFF_STATUS, 32'h0);
        `CHK(rd[17], 1'h1)
      end
    // two modes at once, iq among them, is refused from all-off
    apb(1'h1, `FPS_OFF_CTRL, 32'h0);
    apb(1'h1, `FPS_OFF_CTRL, 32'h9);
    rd_chk(`FPS_OFF_CTRL, 32'h0);
    $display("modes done");
    pres = $urandom | 32'h1;
    apb(1'h1, `FPS_OFF_PRESENT, pres);
    apb(1'h1, `FPS_OFF_CTRL, 32'h0);
    apb(1'h1, `FPS_OFF_CTRL, 32'h51);
    id = 16'h0003;
    u_snd.send(id, 3);
    e_sw = n_sw;
    for (int i = 0; i < 12; i++) begin
      w = 16'($urandom);
      if (i % 4 == 0) w = w % 16'(SLOTS);
      if (i % 4 == 2) w = id;
      if (i == 7) w = 16'(SLOTS);
      e_sw += (w != id);
      id = w;
      u_snd.send(w, 3);
      `CHK(play_segment, w)
      `CHK(play_stream_en, w < SLOTS && pres[w % SLOTS])
    end
    `CHK(n_sw, e_sw)
    u_snd.send(16'h0000, 3);
    `CHK(play_stream_en, 1'h1)
    apb(1'h1, `FPS_OFF_CTRL, 32'h11);
    repeat (3) @(posedge pclk);
    `CHK(play_stream_en, 1'h0)
    apb(1'h1, `FPS_OFF_CTRL, 32'h10);
    u_snd.send(16'h0005, 3);
    `CHK(play_segment, 16'h0000)
    seq_segment_id <= 16'($urandom);
    mf_segment_id  <= 16'($urandom);
    apb(1'h1, `FPS_OFF_INTSEG, 32'h0000_1234);
    for (int s = 0; s < 4; s++) begin
      apb(1'h1, `FPS_OFF_CTRL, 32'(s) << 4);
      repeat (3) @(posedge pclk);
      `CHK(play_segment, s == 0 ? 16'h1234 : s == 1 ? 16'h0000 :
           s == 2 ? seq_segment_id : mf_segment_id)
    end
    $display("segments done");
    for (int m = 0; m < 2; m++) begin
      c0 = n_s[m];
      p0 = n_c[m];
      apb(1'h1, `FPS_OFF_CTRL, 32'h0);
      apb(1'h1, `FPS_OFF_CTRL, m ? 32'h4 : 32'h2);
      u_snd.send(16'h12FF, 3);
      `CHK(n_s[m] + n_c[m], c0 + p0)
      apb(1'h1, `FPS_OFF_CTRL, m ? 32'h104 : 32'h82);
      for (int k = 0; k < 6; k++) begin
        w = 16'($urandom);
        w[7:0] = (k % 3 == 2) ? 8'hFF : w[7:0] % 8'hFF;
        u_snd.send(w, k == 4 ? 12 : 3);
        `CHK({desc_addr, desc_param}, w)
      end
      `CHK(n_s[m] - c0, 6)
      `CHK(n_c[m] - p0, 2)
      if (m) `CHK(pulse_desc_index, 8'h02)
    end
    $display("descriptors done");
    test_done();
  end
endmodule : fps_rx_tb
